// ==== power_up_shutdown_sequencing.sv ====
// Top-level power-up and shutdown sequencer of the controller.
`default_nettype none
module power_up_shutdown_sequencing #(
  parameter int unsigned READY_MAX_CYC = pwr_seq_pkg::READY_MAX_CYC,
  parameter int unsigned SETTLE_CYC    = pwr_seq_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rstn,
  // Power-down control after its internal pulldown; low means shut down.
  input  wire logic         power_down_control,
  // Sampled slow clock and core sleep request.
  input  wire logic         slow_clock_in,
  input  wire logic         sleep_request,
  // Flow request pad.
  output logic              host_flow_request_out,
  output logic              host_flow_request_oe,
  // Other pad enables and pulls.
  output logic [2:0]        drive_en,
  output logic [17:0]       pulls,
  // Status.
  output logic [1:0]        power_state,
  output logic              core_reset_n,
  output logic              ready_timeout
);
  typedef struct packed {
    pwr_seq_pkg::power_state_t            state;
    logic [pwr_seq_pkg::CNT_W-1:0]        cnt;
    logic [pwr_seq_pkg::EDGE_W-1:0]       edges;
    logic                                 slow_prev;
    logic                                 req;
    logic                                 core_rst_n;
    logic                                 timeout;
  } seq_state_t;

  seq_state_t cur;
  seq_state_t next_cur;
  pad_ctrl_if pads ();

  always_comb begin
    next_cur = cur;
    next_cur.slow_prev = slow_clock_in;
    if (!power_down_control) begin
      // Undriven control reads low and keeps everything in shutdown.
      next_cur.state      = pwr_seq_pkg::SHUTDOWN;
      next_cur.cnt        = '0;
      next_cur.edges      = '0;
      next_cur.req        = 1'b1;
      next_cur.core_rst_n = 1'b0;
      next_cur.timeout    = 1'b0;
    end else begin
      unique case (cur.state)
        pwr_seq_pkg::SHUTDOWN: begin
          next_cur.state = pwr_seq_pkg::POWER_UP;
        end
        pwr_seq_pkg::POWER_UP: begin
          if (cur.cnt != pwr_seq_pkg::CNT_W'(READY_MAX_CYC)) begin
            next_cur.cnt = cur.cnt + 1'b1;
          end
          if (slow_clock_in && !cur.slow_prev &&
              cur.edges != pwr_seq_pkg::EDGE_W'(pwr_seq_pkg::SLOW_STABLE_CYC)) begin
            next_cur.edges = cur.edges + 1'b1;
          end
          // Ready once the slow clock has run 64 cycles and the fast clock has settled,
          // and no later than the 100 ms bound.
          if ((cur.edges == pwr_seq_pkg::EDGE_W'(pwr_seq_pkg::SLOW_STABLE_CYC) &&
               cur.cnt >= pwr_seq_pkg::CNT_W'(SETTLE_CYC)) ||
              cur.cnt == pwr_seq_pkg::CNT_W'(READY_MAX_CYC - 1)) begin
            next_cur.state      = pwr_seq_pkg::ACTIVE;
            next_cur.req        = 1'b0;
            next_cur.core_rst_n = 1'b1;
            next_cur.timeout    = (cur.edges != pwr_seq_pkg::EDGE_W'(pwr_seq_pkg::SLOW_STABLE_CYC));
          end
        end
        pwr_seq_pkg::ACTIVE: begin
          if (sleep_request) begin
            next_cur.state = pwr_seq_pkg::DEEP_SLEEP;
          end
        end
        pwr_seq_pkg::DEEP_SLEEP: begin
          if (!sleep_request) begin
            next_cur.state = pwr_seq_pkg::ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur <= '{state: pwr_seq_pkg::SHUTDOWN, cnt: '0, edges: '0, slow_prev: 1'b0,
               req: 1'b1, core_rst_n: 1'b0, timeout: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign pads.state = cur.state;

  pad_mode_ctrl u_pads (
    .clock    (clock),
    .rstn     (rstn),
    .ctl      (pads.pad),
    .drive_en (drive_en),
    .pulls    (pulls)
  );

  // Request pad is driven only once the pad controller has left the shutdown pattern.
  assign host_flow_request_oe  = drive_en[1];
  assign host_flow_request_out = cur.req;
  assign power_state           = cur.state;
  assign core_reset_n          = cur.core_rst_n;
  assign ready_timeout         = cur.timeout;
endmodule
`default_nettype wire

// ==== pwr_seq_pkg.sv ====
// Package of constants and types for the power-up and shutdown sequencer.
`default_nettype none
package pwr_seq_pkg;
  localparam int unsigned CLOCK_MHZ       = 200;
  localparam int unsigned READY_MAX_MS    = 100;
  localparam int unsigned SLOW_STABLE_CYC = 64;
  localparam int unsigned SETTLE_MS       = 2;
  localparam int unsigned CYC_PER_MS      = CLOCK_MHZ * 1000;
  localparam int unsigned READY_MAX_CYC   = READY_MAX_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 25;
  localparam int unsigned EDGE_W          = 7;
  // Pull patterns, two bits a pad, serial in first: 0 none, 1 up, 2 down.
  localparam logic [17:0] PULLS_SHUTDOWN  = 18'h1_56a9;
  localparam logic [17:0] PULLS_ACTIVE    = 18'h1_42a8;

  typedef enum logic [1:0] {
    SHUTDOWN,
    POWER_UP,
    ACTIVE,
    DEEP_SLEEP
  } power_state_t;

  // Pull codes for one pad.
  typedef enum logic [1:0] {
    PULL_NONE,
    PULL_UP,
    PULL_DOWN
  } pull_t;
endpackage
`default_nettype wire

// ==== pad_ctrl_if.sv ====
// Interface carrying the pad mode from the sequencer to the pad controller.
`default_nettype none
interface pad_ctrl_if;
  pwr_seq_pkg::power_state_t state;
  modport seq (output state);
  modport pad (input state);
endinterface
`default_nettype wire

// ==== pad_mode_ctrl.sv ====
// Pad controller setting output enables and pulls per power state.
`default_nettype none
module pad_mode_ctrl (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rstn,
  // State from the sequencer.
  pad_ctrl_if.pad           ctl,
  // Pad controls: bit order is serial out, request, debug out.
  output var  logic [2:0]   drive_en,
  // Pulls: serial in, grant, serial out, request, bit clk, sync, audio in, audio out, debug.
  output var  logic [17:0]  pulls
);
  typedef struct packed {
    logic [2:0]  drive_en;
    logic [17:0] pulls;
  } pad_state_t;

  pad_state_t cur;
  pad_state_t next_cur;

  always_comb begin
    next_cur = cur;
    if (ctl.state == pwr_seq_pkg::ACTIVE || ctl.state == pwr_seq_pkg::DEEP_SLEEP) begin
      next_cur.drive_en = 3'h7;
      next_cur.pulls = {pwr_seq_pkg::PULL_UP, pwr_seq_pkg::PULL_UP, pwr_seq_pkg::PULL_NONE,
                        pwr_seq_pkg::PULL_NONE, pwr_seq_pkg::PULL_DOWN, pwr_seq_pkg::PULL_DOWN,
                        pwr_seq_pkg::PULL_DOWN, pwr_seq_pkg::PULL_DOWN,
                        pwr_seq_pkg::PULL_NONE};
    end else begin
      next_cur.drive_en = 3'h0;
      next_cur.pulls = {pwr_seq_pkg::PULL_UP, pwr_seq_pkg::PULL_UP, pwr_seq_pkg::PULL_UP,
                        pwr_seq_pkg::PULL_UP, pwr_seq_pkg::PULL_DOWN, pwr_seq_pkg::PULL_DOWN,
                        pwr_seq_pkg::PULL_DOWN, pwr_seq_pkg::PULL_DOWN,
                        pwr_seq_pkg::PULL_UP};
    end
  end

  // Reset value is the shutdown pad pattern.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur <= '{drive_en: 3'h0, pulls: pwr_seq_pkg::PULLS_SHUTDOWN};
    end else begin
      cur <= next_cur;
    end
  end

  assign drive_en = cur.drive_en;
  assign pulls    = cur.pulls;
endmodule
`default_nettype wire

// ==== pwr_seq_monitor.sv ====
// Port checker of the power-up and shutdown sequencer.
`default_nettype none
module pwr_seq_monitor #(
  parameter int unsigned READY_MAX_CYC = 2000
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        power_down_control,
  input wire logic        host_flow_request_out,
  input wire logic        host_flow_request_oe,
  input wire logic [2:0]  drive_en,
  input wire logic [17:0] pulls,
  input wire logic [1:0]  power_state,
  input wire logic        core_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned waited;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) waited <= 0;
    else waited <= (power_down_control && host_flow_request_out) ? waited + 1 : 0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_release; !power_down_control ##1 power_down_control; endsequence
  sequence s_down; !power_state[1] ##1 !power_state[1]; endsequence
  sequence s_up; power_state[1] ##1 power_state[1]; endsequence
  chk_enter_shutdown: assert property (!power_down_control |=> power_state == 2'h0)
    else $error("shutdown not entered");
  chk_core_held: assert property (!power_state[1] |-> !core_reset_n)
    else $error("core not held in reset");
  chk_power_up_start: assert property (s_release |=> power_state == 2'h1)
    else $error("power-up did not start");
  chk_request_idle: assert property (!power_state[1] |-> host_flow_request_out)
    else $error("request low before ready");
  chk_ready_bound: assert property (waited <= READY_MAX_CYC + 2)
    else $error("ready too late");
  chk_ready_stands: assert property (!host_flow_request_out && power_down_control |=>
    !host_flow_request_out)
    else $error("ready dropped");
  chk_pads_hiz: assert property (s_down |-> drive_en == 3'h0 && !host_flow_request_oe)
    else $error("pad driven while down");
  chk_pulls_shut: assert property (s_down |-> pulls == 18'h1_56a9)
    else $error("shutdown pulls wrong");
  chk_pads_active: assert property (s_up |-> pulls == 18'h1_42a8 && drive_en == 3'h7)
    else $error("active pads wrong");
endmodule
bind power_up_shutdown_sequencing pwr_seq_monitor #(.READY_MAX_CYC(READY_MAX_CYC)) mon (
  .clock(clock), .rstn(rstn), .power_down_control(power_down_control),
  .host_flow_request_out(host_flow_request_out), .host_flow_request_oe(host_flow_request_oe),
  .drive_en(drive_en), .pulls(pulls), .power_state(power_state), .core_reset_n(core_reset_n));
`default_nettype wire

// ==== host_model.sv ====
// Host model driving the power-down control and the slow clock.
`default_nettype none
module host_model #(
  parameter int unsigned LOW_MIN = 50
) (
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic [15:0] slow_half,
  output var  logic        power_down_control,
  output var  logic        slow_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned low_cnt = 0;
  int unsigned slow_cnt = 0;
  // Both outputs settle low at the first edge, while the bench still holds reset.
  // Release waits out the minimum low time; supplies are taken as stable.
  always @(posedge clock) begin
    low_cnt <= power_down_control ? 0 : low_cnt + 1;
    power_down_control <= run && (power_down_control || low_cnt >= LOW_MIN);
    slow_cnt <= (slow_cnt + 1 >= slow_half) ? 0 : slow_cnt + 1;
    if (!power_down_control || slow_half == 16'h0000) slow_clock_in <= 1'b0;
    else if (slow_cnt + 1 >= slow_half) slow_clock_in <= !slow_clock_in;
  end
endmodule
`default_nettype wire

// ==== test_power_up_shutdown_sequencing.sv ====
// Self-checking bench of the power-up and shutdown sequencer.
`default_nettype none
module test_power_up_shutdown_sequencing;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] half; int lo; int hi; logic tmo;} row_t;
  row_t        rows [3] = '{'{16'h0001, 198, 210, 0}, '{16'h0004, 500, 535, 0},
                            '{16'h0000, 1996, 2004, 1}};
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        sleep_request = 1'b0;
  logic        run = 1'b0;
  logic [15:0] slow_half = 16'h0000;
  logic        pdc, slow, req, oe, core_reset_n, ready_timeout;
  logic [2:0]  drive_en;
  logic [17:0] pulls;
  logic [1:0]  power_state;
  int          failures = 0;
  int          comparisons = 0;
  int          n;
  initial forever #2.5 clock = !clock;
  host_model host (.clock(clock), .run(run), .slow_half(slow_half),
    .power_down_control(pdc), .slow_clock_in(slow));
  power_up_shutdown_sequencing #(.READY_MAX_CYC(2000), .SETTLE_CYC(200)) uut (
    .clock(clock), .rstn(rstn), .power_down_control(pdc), .slow_clock_in(slow),
    .sleep_request(sleep_request), .host_flow_request_out(req), .host_flow_request_oe(oe),
    .drive_en(drive_en), .pulls(pulls), .power_state(power_state),
    .core_reset_n(core_reset_n), .ready_timeout(ready_timeout));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ready(output int cnt);
    int k;
    cnt = 0;
    for (k = 0; req !== 1'b0; k++) begin
      @(negedge clock);
      if (pdc) cnt++;
      if (k > 4000) begin
        failures++;
        wrap_up();
      end
    end
  endtask
  task automatic go(input logic r);
    @(posedge clock);
    run <= r;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      go(1'b0);
      slow_half <= rows[i].half;
      repeat (60) @(negedge clock);
      check(power_state, 2'h0);
      check({req, pulls, drive_en}, {1'b1, 18'h1_56a9, 3'h0});
      go(1'b1);
      wait_ready(n);
      check(n >= rows[i].lo && n <= rows[i].hi, 1);
      check(ready_timeout, rows[i].tmo);
      repeat (2) @(negedge clock);
      check({power_state, core_reset_n, oe}, 4'hb);
      check({pulls, drive_en}, {18'h1_42a8, 3'h7});
      @(posedge clock) sleep_request <= 1'b1;
      repeat (3) @(negedge clock);
      check({power_state, req, drive_en}, {2'h3, 1'b0, 3'h7});
      @(posedge clock) sleep_request <= 1'b0;
      $display("row %0d done", i);
    end
    go(1'b0);
    repeat (60) @(negedge clock);
    go(1'b1);
    repeat (100) @(negedge clock);
    check({power_state, req, oe}, 4'h6);
    go(1'b0);
    repeat (3) @(negedge clock);
    check({power_state, core_reset_n}, 3'h0);
    go(1'b1);
    wait_ready(n);
    check(n <= 2002, 1);
    $display("abort test done");
    @(posedge clock) rstn <= 1'b0;
    @(negedge clock);
    check({power_state, req, oe, pulls}, {2'h0, 2'h2, 18'h1_56a9});
    @(posedge clock) rstn <= 1'b1;
    repeat (2) @(negedge clock);
    check(power_state, 2'h1);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
